// >>> inc/mcs_defs.vh
// Constants for the measurement conversion sequencer
`ifndef MCS_DEFS_VH
`define MCS_DEFS_VH

// ****************************************
// Clock and time base
// ****************************************
`define MCS_CLK_NS 5
`define MCS_US_NS 1000
`define MCS_US_CYC (`MCS_US_NS / `MCS_CLK_NS)
`define MCS_DLY_STEP_MS 2
`define MCS_DLY_STEP_US (`MCS_DLY_STEP_MS * 1000)
`define MCS_CT_MIN_US 13'h0032
`define MCS_CT_MAX_US 13'h1018
`define MCS_CT_RST_US 13'h041c

// ****************************************
// Register byte offsets
// ****************************************
`define MCS_A_CONFIG 8'h00
`define MCS_A_ADCCFG 8'h04
`define MCS_A_CTSH 8'h08
`define MCS_A_CTBUS 8'h0c
`define MCS_A_CTTMP 8'h10
`define MCS_A_CAL 8'h14
`define MCS_A_CUR 8'h18
`define MCS_A_VBUS 8'h1c
`define MCS_A_TEMP 8'h20
`define MCS_A_PWR 8'h24
`define MCS_A_ENERGY 8'h28
`define MCS_A_CHARGE 8'h2c
`define MCS_A_DIAG 8'h30

// ****************************************
// Fields and reset values
// ****************************************
`define MCS_DLY_RNG 7:0
`define MCS_EN_RNG 2:0
`define MCS_CONT_BIT 3
`define MCS_AVG_RNG 7:4
`define MCS_CT_RNG 12:0
`define MCS_CAL_RNG 15:0
`define MCS_ADCCFG_RST 8'h08
`define MCS_AVG_MAX 4'ha
`define MCS_DIAG_RDY 0
`define MCS_DIAG_ACCV 1
`define MCS_DIAG_BUSY 2

// ****************************************
// Arithmetic scaling
// ****************************************
`define MCS_CUR_MSB 35
`define MCS_CUR_LSB 12
`define MCS_PWR_MSB 43
`define MCS_PWR_LSB 12

`endif

// >>> rtl/mcs_tick.v
// Microsecond enable pulse divider
`timescale 1ns/1ps
module mcs_tick #(
  parameter [11:0] CYC = 12'h0c8
) (
  // Clock and reset
  input wire clk_i,
  input wire sys_rst_i,
  // Realign the divider on restart
  input wire clr_i,
  // One-cycle pulse every microsecond
  output reg tick_o
);
  reg [11:0] cnt;

  always @(posedge clk_i) begin
    if (sys_rst_i || clr_i) begin
      cnt <= 12'h000;
      tick_o <= 1'b0;
    end else if (cnt == CYC - 12'h001) begin
      cnt <= 12'h000;
      tick_o <= 1'b1;
    end else begin
      cnt <= cnt + 12'h001;
      tick_o <= 1'b0;
    end
  end
endmodule

// >>> rtl/mcs_calc.v
// Current and power arithmetic, one request per cycle, one cycle latency
`timescale 1ns/1ps
`include "mcs_defs.vh"
module mcs_calc (
  // Clock and reset
  input wire clk_i,
  input wire sys_rst_i,
  // Request
  input wire go_i,
  input wire pwr_i,
  input wire avg_i,
  input wire [19:0] shunt_i,
  input wire [19:0] bus_i,
  input wire [23:0] cur_i,
  input wire [15:0] cal_i,
  // Result
  output reg done_o,
  output reg pwr_o,
  output reg avg_o,
  output reg [23:0] cur_o,
  output reg [31:0] power_o
);
  wire signed [36:0] prod_c = $signed(shunt_i) * $signed({1'b0, cal_i});
  wire signed [44:0] prod_p = $signed(cur_i) * $signed({1'b0, bus_i});

  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      done_o <= 1'b0;
      pwr_o <= 1'b0;
      avg_o <= 1'b0;
      cur_o <= 24'h000000;
      power_o <= 32'h00000000;
    end else begin
      done_o <= go_i;
      pwr_o <= pwr_i;
      avg_o <= avg_i;
      if (go_i && !pwr_i) begin
        // Signed product keeps both current directions
        cur_o <= prod_c[`MCS_CUR_MSB:`MCS_CUR_LSB];
      end
      if (go_i && pwr_i) begin
        // Power uses the latest current and the newest bus sample
        if (cal_i == 16'h0000) begin
          power_o <= 32'h00000000;
        end else begin
          power_o <= prod_p[`MCS_PWR_MSB:`MCS_PWR_LSB];
        end
      end
    end
  end
endmodule

// >>> rtl/mcs_top.v
// Conversion sequencer with averaging, background arithmetic and APB registers
`timescale 1ns/1ps
`include "mcs_defs.vh"

// How it works
// - Current/charge after shunt, power/energy after bus
// - Power uses last current, newest bus
// - Zero calibration forces power, energy, charge zero
// - Accumulate samples, then average and load
// - Energy accumulates every bus conversion, charge every shunt conversion, unaveraged
// - Arithmetic runs beside conversions; sequence end adds three cycles for the averaged results
// - Mode field selects shunt, bus, temperature
// - Per-channel conversion time, 50 us to 4.12 ms
// - Enabled channels converted one after another
// - Single average: results land at conversion end
// - Bus/temp hold until next complete result; current/power rewritten at every sequence end, even with shunt or bus off
// - Continuous mode loops without host action
// - Triggered mode: one sequence, then shutdown
// - Mode write aborts and restarts activity
// - Ready flag after all conversions and averaging
// - Ready clears on status read or on a mode write that enables a channel
// - Accumulations valid only in continuous mode
// - Start delay 0 to 510 ms, 2 ms steps
// - Shunt results handled as signed values
// - Averaging counts from 1 to 1024
// - One averaging count for all channels
module mcs_top #(
  parameter US_CYC = `MCS_US_CYC,
  parameter DLY_STEP_US = `MCS_DLY_STEP_US
) (
  // Clock and reset
  input wire clk_i,
  input wire sys_rst_i,
  // APB slave
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [31:0] paddr_i,
  input wire [31:0] pwdata_i,
  output reg [31:0] prdata_o,
  output reg pready_o,
  output reg pslverr_o,
  // Converter front end
  input wire [19:0] adc_data_i,
  output reg adc_start_o,
  output reg [2:0] adc_ch_o,
  // Status
  output reg conv_ready_o
);
  localparam [5:0] S_IDLE = 6'h01;
  localparam [5:0] S_DLY = 6'h02;
  localparam [5:0] S_CONV = 6'h04;
  localparam [5:0] S_FIN1 = 6'h08;
  localparam [5:0] S_FIN2 = 6'h10;
  localparam [5:0] S_FIN3 = 6'h20;
  localparam [11:0] TICK_CYC = US_CYC[11:0];
  localparam [11:0] DLY_STEP = DLY_STEP_US[11:0];
  localparam [7:0] ADCCFG_RST = `MCS_ADCCFG_RST;

  // ****************************************
  // Registers
  // ****************************************
  reg [7:0] dly_cfg;
  reg [2:0] en;
  reg cont;
  reg [3:0] avg;
  reg [12:0] ct_sh;
  reg [12:0] ct_bus;
  reg [12:0] ct_tmp;
  reg [15:0] cal;
  reg [23:0] cur_reg;
  reg [19:0] vbus_reg;
  reg [19:0] temp_reg;
  reg [31:0] pwr_reg;
  reg [47:0] energy;
  reg [39:0] charge;
  reg [23:0] cur_last;
  reg [5:0] state;
  reg [19:0] us_cnt;
  reg [10:0] pass_cnt;
  reg [29:0] sum_sh;
  reg [29:0] sum_bus;
  reg [29:0] sum_tmp;
  reg [31:0] rmux;

  // ****************************************
  // APB decode
  // ****************************************
  wire [7:0] a = paddr_i[7:0];
  wire mapped = (paddr_i[31:8] == 24'h000000) && (a[1:0] == 2'b00) && (a <= `MCS_A_DIAG);
  wire acc = psel_i && penable_i && pready_o;
  wire wr = acc && pwrite_i && mapped;
  wire rd = acc && !pwrite_i && mapped;
  wire mode_wr = wr && (a == `MCS_A_ADCCFG);
  wire diag_rd = rd && (a == `MCS_A_DIAG);
  wire [2:0] en_new = pwdata_i[`MCS_EN_RNG];

  // ****************************************
  // Sequencing helpers
  // ****************************************
  wire tick;
  wire [2:0] ch = adc_ch_o;
  wire [2:0] first_ch = en & (~en + 3'b001);
  wire [2:0] hi_mask = {ch[1:0], 1'b0} | {ch[0], 2'b00};
  wire [2:0] rest = en & hi_mask;
  wire [2:0] next_ch = rest & (~rest + 3'b001);
  wire [12:0] ct_sel = ch[0] ? ct_sh : (ch[1] ? ct_bus : ct_tmp);
  wire [12:0] ct_lo = (ct_sel < `MCS_CT_MIN_US) ? `MCS_CT_MIN_US : ct_sel;
  wire [12:0] ct_eff = (ct_lo > `MCS_CT_MAX_US) ? `MCS_CT_MAX_US : ct_lo;
  wire conv_end = (state == S_CONV) && tick && (us_cnt == {7'h00, ct_eff - 13'h0001});
  wire [3:0] avg_c = (avg > `MCS_AVG_MAX) ? `MCS_AVG_MAX : avg;
  wire [10:0] avg_n = 11'h001 << avg_c;
  wire [19:0] dly_tgt = dly_cfg * DLY_STEP;
  wire [29:0] adc_sx = {{10{adc_data_i[19]}}, adc_data_i};
  wire [29:0] adc_zx = {10'h000, adc_data_i};
  wire [29:0] avg_sh_w = $signed(sum_sh) >>> avg_c;
  wire [29:0] avg_bus_w = sum_bus >> avg_c;
  wire [29:0] avg_tmp_w = $signed(sum_tmp) >>> avg_c;

  // ****************************************
  // Background arithmetic
  // ****************************************
  reg calc_go;
  reg calc_pwr;
  reg calc_avg;
  reg [19:0] calc_sh;
  reg [19:0] calc_bus;
  reg [23:0] calc_cur;
  wire c_done;
  wire c_pwr;
  wire c_avg;
  wire [23:0] c_cur;
  wire [31:0] c_power;

  // Issued on the conversion's last cycle so no time is added
  always @* begin
    calc_go = 1'b0;
    calc_pwr = 1'b0;
    calc_avg = 1'b0;
    calc_sh = adc_data_i;
    calc_bus = adc_data_i;
    calc_cur = cur_last;
    if (conv_end && ch[0]) begin
      calc_go = 1'b1;
    end else if (conv_end && ch[1]) begin
      calc_go = 1'b1;
      calc_pwr = 1'b1;
    end else if (state == S_FIN1) begin
      calc_go = 1'b1;
      calc_avg = 1'b1;
      calc_sh = avg_sh_w[19:0];
    end else if (state == S_FIN2) begin
      calc_go = 1'b1;
      calc_pwr = 1'b1;
      calc_avg = 1'b1;
      calc_bus = avg_bus_w[19:0];
      calc_cur = c_cur;
    end
  end

  mcs_tick #(
    .CYC(TICK_CYC)
  ) u_tick (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .clr_i(mode_wr),
    .tick_o(tick)
  );

  mcs_calc u_calc (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .go_i(calc_go),
    .pwr_i(calc_pwr),
    .avg_i(calc_avg),
    .shunt_i(calc_sh),
    .bus_i(calc_bus),
    .cur_i(calc_cur),
    .cal_i(cal),
    .done_o(c_done),
    .pwr_o(c_pwr),
    .avg_o(c_avg),
    .cur_o(c_cur),
    .power_o(c_power)
  );

  // ****************************************
  // Register read mux
  // ****************************************
  always @* begin
    rmux = 32'h00000000;
    case (a)
      `MCS_A_CONFIG: rmux = {24'h000000, dly_cfg};
      `MCS_A_ADCCFG: rmux = {24'h000000, avg, cont, en};
      `MCS_A_CTSH: rmux = {19'h00000, ct_sh};
      `MCS_A_CTBUS: rmux = {19'h00000, ct_bus};
      `MCS_A_CTTMP: rmux = {19'h00000, ct_tmp};
      `MCS_A_CAL: rmux = {16'h0000, cal};
      `MCS_A_CUR: rmux = {{8{cur_reg[23]}}, cur_reg};
      `MCS_A_VBUS: rmux = {12'h000, vbus_reg};
      `MCS_A_TEMP: rmux = {{12{temp_reg[19]}}, temp_reg};
      `MCS_A_PWR: rmux = pwr_reg;
      `MCS_A_ENERGY: rmux = energy[31:0];
      `MCS_A_CHARGE: rmux = charge[31:0];
      `MCS_A_DIAG: begin
        rmux = {29'h00000000, state != S_IDLE, cont, conv_ready_o};
      end
      default: rmux = 32'h00000000;
    endcase
  end

  // One wait state; write and read happen at the pready edge
  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      pready_o <= 1'b0;
      prdata_o <= 32'h00000000;
      pslverr_o <= 1'b0;
    end else begin
      pready_o <= psel_i && penable_i && !pready_o;
      if (psel_i && penable_i && !pready_o) begin
        prdata_o <= (mapped && !pwrite_i) ? rmux : 32'h00000000;
        pslverr_o <= !mapped;
      end
    end
  end

  // ****************************************
  // Configuration registers
  // ****************************************
  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      dly_cfg <= 8'h00;
      en <= ADCCFG_RST[`MCS_EN_RNG];
      cont <= ADCCFG_RST[`MCS_CONT_BIT];
      avg <= ADCCFG_RST[`MCS_AVG_RNG];
      ct_sh <= `MCS_CT_RST_US;
      ct_bus <= `MCS_CT_RST_US;
      ct_tmp <= `MCS_CT_RST_US;
      cal <= 16'h0000;
    end else if (wr) begin
      case (a)
        `MCS_A_CONFIG: dly_cfg <= pwdata_i[`MCS_DLY_RNG];
        `MCS_A_ADCCFG: begin
          en <= en_new;
          cont <= pwdata_i[`MCS_CONT_BIT];
          avg <= pwdata_i[`MCS_AVG_RNG];
        end
        `MCS_A_CTSH: ct_sh <= pwdata_i[`MCS_CT_RNG];
        `MCS_A_CTBUS: ct_bus <= pwdata_i[`MCS_CT_RNG];
        `MCS_A_CTTMP: ct_tmp <= pwdata_i[`MCS_CT_RNG];
        `MCS_A_CAL: cal <= pwdata_i[`MCS_CAL_RNG];
        default: cal <= cal;
      endcase
    end
  end

  // ****************************************
  // Sequencer
  // ****************************************
  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      state <= S_IDLE;
      us_cnt <= 20'h00000;
      pass_cnt <= 11'h000;
      adc_ch_o <= 3'b000;
      adc_start_o <= 1'b0;
      sum_sh <= 30'h00000000;
      sum_bus <= 30'h00000000;
      sum_tmp <= 30'h00000000;
    end else if (mode_wr) begin
      // Abort whatever runs; delay restarts from this write
      state <= (en_new != 3'b000) ? S_DLY : S_IDLE;
      us_cnt <= 20'h00000;
      pass_cnt <= 11'h000;
      adc_ch_o <= 3'b000;
      adc_start_o <= 1'b0;
      sum_sh <= 30'h00000000;
      sum_bus <= 30'h00000000;
      sum_tmp <= 30'h00000000;
    end else begin
      adc_start_o <= 1'b0;
      case (state)
        S_IDLE: begin
          us_cnt <= 20'h00000;
        end
        S_DLY: begin
          if (us_cnt >= dly_tgt) begin
            state <= S_CONV;
            us_cnt <= 20'h00000;
            adc_ch_o <= first_ch;
            adc_start_o <= 1'b1;
          end else if (tick) begin
            us_cnt <= us_cnt + 20'h00001;
          end
        end
        S_CONV: begin
          if (conv_end) begin
            if (ch[0]) begin
              sum_sh <= sum_sh + adc_sx;
            end
            if (ch[1]) begin
              sum_bus <= sum_bus + adc_zx;
            end
            if (ch[2]) begin
              sum_tmp <= sum_tmp + adc_sx;
            end
            us_cnt <= 20'h00000;
            if (next_ch != 3'b000) begin
              adc_ch_o <= next_ch;
              adc_start_o <= 1'b1;
            end else if (pass_cnt + 11'h001 == avg_n) begin
              state <= S_FIN1;
              adc_ch_o <= 3'b000;
            end else begin
              pass_cnt <= pass_cnt + 11'h001;
              adc_ch_o <= first_ch;
              adc_start_o <= 1'b1;
            end
          end else if (tick) begin
            us_cnt <= us_cnt + 20'h00001;
          end
        end
        S_FIN1: begin
          state <= S_FIN2;
        end
        S_FIN2: begin
          state <= S_FIN3;
        end
        S_FIN3: begin
          pass_cnt <= 11'h000;
          sum_sh <= 30'h00000000;
          sum_bus <= 30'h00000000;
          sum_tmp <= 30'h00000000;
          if (cont) begin
            state <= S_CONV;
            adc_ch_o <= first_ch;
            adc_start_o <= 1'b1;
          end else begin
            state <= S_IDLE;
          end
        end
        default: state <= S_IDLE;
      endcase
    end
  end

  // ****************************************
  // Result registers and accumulations
  // ****************************************
  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      cur_reg <= 24'h000000;
      vbus_reg <= 20'h00000;
      temp_reg <= 20'h00000;
      pwr_reg <= 32'h00000000;
      energy <= 48'h000000000000;
      charge <= 40'h0000000000;
      cur_last <= 24'h000000;
    end else begin
      // Immediate bus and temperature results without averaging
      if (conv_end && avg_c == 4'h0 && ch[1]) begin
        vbus_reg <= adc_data_i;
      end
      if (conv_end && avg_c == 4'h0 && ch[2]) begin
        temp_reg <= adc_data_i;
      end
      // Held otherwise; only a finished result replaces them
      if (state == S_FIN1) begin
        if (en[1]) begin
          vbus_reg <= avg_bus_w[19:0];
        end
        if (en[2]) begin
          temp_reg <= avg_tmp_w[19:0];
        end
      end
      if (c_done && !c_pwr) begin
        cur_last <= c_cur;
        if (c_avg || avg_c == 4'h0) begin
          cur_reg <= c_cur;
        end
      end
      if (c_done && c_pwr && (c_avg || avg_c == 4'h0)) begin
        pwr_reg <= c_power;
      end
      if (cal == 16'h0000) begin
        // A stale power result must not outlive a zero calibration
        pwr_reg <= 32'h00000000;
        energy <= 48'h000000000000;
        charge <= 40'h0000000000;
      end else if (c_done && !c_avg) begin
        if (c_pwr) begin
          energy <= energy + {16'h0000, c_power};
        end else begin
          charge <= charge + {{16{c_cur[23]}}, c_cur};
        end
      end
    end
  end

  // Set wins over a status-read clear in the same cycle; a mode write blocks the set
  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      conv_ready_o <= 1'b0;
    end else if (state == S_FIN3 && !mode_wr) begin
      conv_ready_o <= 1'b1;
    end else if (diag_rd || (mode_wr && en_new != 3'b000)) begin
      conv_ready_o <= 1'b0;
    end
  end
endmodule

// >>> sim/mcs_checker.sv
// Port-level assertions for the conversion sequencer
`timescale 1ns/1ps
module mcs_checker (
  // Clock and reset
  input wire clk_i,
  input wire sys_rst_i,
  // APB slave
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [31:0] paddr_i,
  input wire [31:0] pwdata_i,
  input wire [31:0] prdata_o,
  input wire pready_o,
  input wire pslverr_o,
  // Converter front end
  input wire [19:0] adc_data_i,
  input wire adc_start_o,
  input wire [2:0] adc_ch_o,
  // Status
  input wire conv_ready_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (sys_rst_i);

  // ****
  // Register bus
  // ****
  property p_rdy_pulse;
    pready_o |=> !pready_o;
  endproperty
  a_rdy_pulse: assert property (p_rdy_pulse) else $error("pready longer than one cycle");
  property p_rdy_cause;
    pready_o |-> $past(psel_i && penable_i) && !$past(penable_i, 2);
  endproperty
  a_rdy_cause: assert property (p_rdy_cause) else $error("pready without one wait state");
  property p_err_addr;
    pready_o |-> (pslverr_o == ($past(paddr_i) > 32'h30 || $past(paddr_i[1:0]) != 2'h0));
  endproperty
  a_err_addr: assert property (p_err_addr) else $error("pslverr does not match address");
  property p_wr_zero;
    pready_o && $past(pwrite_i) |-> prdata_o == 32'h0;
  endproperty
  a_wr_zero: assert property (p_wr_zero) else $error("read data not zero on write");

  // ****
  // Sequencer
  // ****
  property p_start_onehot;
    adc_start_o |-> $onehot(adc_ch_o);
  endproperty
  a_start_onehot: assert property (p_start_onehot) else $error("start without one channel");
  property p_start_pulse;
    adc_start_o |=> !adc_start_o;
  endproperty
  a_start_pulse: assert property (p_start_pulse) else $error("start pulse too long");
  property p_conv_hold;
    adc_start_o |=> $stable(adc_ch_o) [*8];
  endproperty
  a_conv_hold: assert property (p_conv_hold) else $error("channel dropped early");
  property p_ch_change;
    $changed(adc_ch_o) && adc_ch_o != 3'h0 |-> adc_start_o;
  endproperty
  a_ch_change: assert property (p_ch_change) else $error("channel switched without start");
  property p_rdy_set;
    $rose(conv_ready_o) |-> $past(adc_ch_o, 3) == 3'h0 && !$past(adc_start_o, 2);
  endproperty
  a_rdy_set: assert property (p_rdy_set) else $error("ready set during conversion");
  property p_rdy_clr;
    $fell(conv_ready_o) |-> $past(psel_i && penable_i && pready_o &&
      ((paddr_i == 32'h30 && !pwrite_i) || (paddr_i == 32'h04 && pwrite_i)));
  endproperty
  a_rdy_clr: assert property (p_rdy_clr) else $error("ready cleared without cause");

  c_start: cover property (adc_start_o);
  c_rdy: cover property ($rose(conv_ready_o));
  c_clr: cover property ($fell(conv_ready_o));
  c_err: cover property (pslverr_o);
endmodule

bind mcs_top mcs_checker u_chk (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .psel_i(psel_i),
  .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
  .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .adc_data_i(adc_data_i),
  .adc_start_o(adc_start_o), .adc_ch_o(adc_ch_o), .conv_ready_o(conv_ready_o));

// >>> sim/mcs_adc_model.sv
// Converter front end model: fixed result per channel
`timescale 1ns/1ps
module mcs_adc_model #(
  parameter [19:0] SHUNT_VAL = 20'hfff00,
  parameter [19:0] BUS_VAL = 20'h02000,
  parameter [19:0] TEMP_VAL = 20'hffe80
) (
  // Clock
  input wire clk_i,
  // Channel select
  input wire [2:0] adc_ch_i,
  // Result
  output reg [19:0] adc_data_o
);
  initial adc_data_o = 20'h5a5a5;
  always @(posedge clk_i) begin
    case (adc_ch_i)
      3'h1: adc_data_o <= SHUNT_VAL;
      3'h2: adc_data_o <= BUS_VAL;
      3'h4: adc_data_o <= TEMP_VAL;
      // Idle lines toggle so a stale sample shows up
      default: adc_data_o <= ~adc_data_o;
    endcase
  end
endmodule

// >>> sim/test_measurement_conversion_sequencer.sv
// Register-level testbench for the conversion sequencer
`timescale 1ns/1ps
`include "mcs_defs.vh"
module test_measurement_conversion_sequencer;
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic psel_i = 1'b0;
  logic penable_i = 1'b0;
  logic pwrite_i = 1'b0;
  logic [31:0] paddr_i = 32'h0;
  logic [31:0] pwdata_i = 32'h0;
  wire [31:0] prdata_o;
  wire pready_o;
  wire pslverr_o;
  wire [19:0] adc_data_i;
  wire adc_start_o;
  wire [2:0] adc_ch_o;
  wire conv_ready_o;
  logic [31:0] rdata;
  logic rerr;
  logic [8:0] seq = 9'h0;
  int starts = 0;
  int busy_cyc = 0;
  int n;
  int error_cnt = 0;
  int tests_run = 0;

  mcs_top #(.US_CYC(4), .DLY_STEP_US(3)) uut (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
    .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .adc_data_i(adc_data_i), .adc_start_o(adc_start_o), .adc_ch_o(adc_ch_o),
    .conv_ready_o(conv_ready_o));
  mcs_adc_model adc (.clk_i(clk_i), .adc_ch_i(adc_ch_o), .adc_data_o(adc_data_i));

  initial forever #2.5 clk_i = ~clk_i;

  always @(posedge clk_i) begin
    if (adc_ch_o != 3'h0) busy_cyc <= busy_cyc + 1;
    if (adc_start_o === 1'b1) begin
      starts <= starts + 1;
      seq <= {seq[5:0], adc_ch_o};
    end
  end

  // ****
  // Tasks
  // ****
  task chk(input string name, input [31:0] exp, input [31:0] got);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask

  // Called just after a rising edge, returns just after one
  task apb(input bit wr, input [31:0] a, input [31:0] d);
    int k;
    psel_i <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i <= wr;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    k = 0;
    do begin
      @(posedge clk_i);
      k++;
    end while (pready_o !== 1'b1 && k < 50);
    chk("pready", 1, pready_o);
    rdata = prdata_o;
    rerr = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    @(posedge clk_i);
  endtask

  task wr(input [31:0] a, input [31:0] d);
    apb(1'b1, a, d);
    chk("wr_err", 0, rerr);
  endtask

  task rd(input string name, input [31:0] a, input [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(name, exp, rdata);
  endtask

  task wait_rdy;
    int k;
    k = 0;
    while (conv_ready_o !== 1'b1 && k < 5000) begin
      @(posedge clk_i);
      k++;
    end
    chk("ready", 1, conv_ready_o);
  endtask

  task wait_start(output int k);
    k = 0;
    do begin
      @(posedge clk_i);
      k++;
    end while (adc_start_o !== 1'b1 && k < 5000);
  endtask

  task conclude;
    $display("TB: %0d checks, %0d errors", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // Whole run needs well under 10k cycles
  initial begin
    #100000;
    error_cnt++;
    conclude();
  end

  // ****
  // Tests
  // ****
  initial begin
    repeat (4) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    @(posedge clk_i);
    rd("adc_cfg", `MCS_A_ADCCFG, 32'h08);
    rd("ct_shunt", `MCS_A_CTSH, 32'h41c);
    rd("delay", `MCS_A_CONFIG, 32'h0);
    rd("cal", `MCS_A_CAL, 32'h0);
    wr(`MCS_A_DIAG, 32'hff);
    // Shut down after reset, yet the continuous bit is set
    rd("diag", `MCS_A_DIAG, 32'h2);
    apb(1'b1, 32'h34, 32'h1);
    chk("unmapped", 1, rerr);
    apb(1'b0, 32'h06, 32'h0);
    chk("unaligned", 1, rerr);
    // Times read back as written; the clamp acts on timing only
    wr(`MCS_A_CTSH, 32'h0a);
    rd("ct_min", `MCS_A_CTSH, 32'h0a);
    wr(`MCS_A_CTBUS, 32'h1388);
    rd("ct_max", `MCS_A_CTBUS, 32'h1388);
    wr(`MCS_A_CTBUS, 32'h32);
    wr(`MCS_A_CTTMP, 32'h32);
    wr(`MCS_A_CAL, 32'h1000);
    // Continuous, shunt and bus, two samples per result
    wr(`MCS_A_ADCCFG, 32'h1b);
    wait_rdy();
    rd("cur", `MCS_A_CUR, 32'hffffff00);
    rd("vbus", `MCS_A_VBUS, 32'h2000);
    rd("power", `MCS_A_PWR, 32'hfffffe00);
    rd("charge", `MCS_A_CHARGE, 32'hfffffe00);
    rd("energy", `MCS_A_ENERGY, 32'hfffffc00);
    rd("diag_run", `MCS_A_DIAG, 32'h7);
    chk("rdy_clr", 0, conv_ready_o);
    wait_rdy();
    rd("charge2", `MCS_A_CHARGE, 32'hfffffc00);
    rd("energy2", `MCS_A_ENERGY, 32'hfffff800);
    wr(`MCS_A_ADCCFG, 32'h08);
    chk("rdy_shutdn", 1, conv_ready_o);
    rd("diag_stop", `MCS_A_DIAG, 32'h3);
    // Triggered, all channels, zero calibration
    wr(`MCS_A_CAL, 32'h0);
    rd("power_cal0", `MCS_A_PWR, 32'h0);
    starts = 0;
    busy_cyc = 0;
    wr(`MCS_A_ADCCFG, 32'h07);
    wait_start(n);
    // Write edge, delay cycle, then start
    chk("dly0", 1, n);
    wait_rdy();
    chk("starts", 3, starts);
    chk("order", 9'b001_010_100, seq);
    chk("busy", 1, busy_cyc >= 597 && busy_cyc <= 603);
    rd("power0", `MCS_A_PWR, 32'h0);
    rd("energy0", `MCS_A_ENERGY, 32'h0);
    rd("charge0", `MCS_A_CHARGE, 32'h0);
    rd("temp", `MCS_A_TEMP, 32'hfffffe80);
    rd("diag_trg", `MCS_A_DIAG, 32'h1);
    rd("diag_clr", `MCS_A_DIAG, 32'h0);
    repeat (300) @(posedge clk_i);
    chk("idle", 3, starts);
    // Start delay of two steps, temperature averaged over two
    wr(`MCS_A_CONFIG, 32'h2);
    starts = 0;
    wr(`MCS_A_ADCCFG, 32'h14);
    wait_start(n);
    chk("dly2", 1, n >= 24 && n <= 26);
    wait_rdy();
    chk("avg_starts", 2, starts);
    rd("temp_avg", `MCS_A_TEMP, 32'hfffffe80);
    // Mode write in mid-conversion restarts the run
    starts = 0;
    wr(`MCS_A_ADCCFG, 32'h09);
    wait_start(n);
    repeat (20) @(posedge clk_i);
    wr(`MCS_A_ADCCFG, 32'h01);
    chk("abort", 0, conv_ready_o);
    wait_rdy();
    chk("restart", 2, starts);
    conclude();
  end
endmodule
